// ---- hdl/aliu_pin_change.sv ----
// aliu_pin_change: flags any level change on the watched pins.
// assumes: pins synchronous to clk_i; restart when the source swaps.
`timescale 1ns/1ps
module aliu_pin_change (
	input wire logic clk_i,
	input wire logic rst_i,
	aliu_pin_if.det pin
);
	import aliu_pkg::*;

	typedef struct packed {
		logic [PIN_W-1:0] prev;
		logic armed;
	} aliu_det_s;

	aliu_det_s st;
	aliu_det_s next_st;
	logic [PIN_W-1:0] diff;

	// per-bit compare against the last sample
	genvar g;
	for (g = 0; g < PIN_W; g++) begin : g_bit
		assign diff[g] = st.prev[g] ^ pin.pins[g];
	end

	// no change is reported before a first sample is held
	assign pin.changed = st.armed & (|diff) & ~pin.restart;

	// sample pins; restart drops the stale reference
	always_comb begin
		next_st = st;
		next_st.prev = pin.pins;
		next_st.armed = ~pin.restart;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st.prev <= PINS_RST;
			st.armed <= 1'b0;
		end else begin
			st <= next_st;
		end
	end
endmodule // aliu_pin_change

// ---- hdl/aliu_pin_if.sv ----
// aliu_pin_if: carries watched pins and their change pulse.
// assumes: main module drives pins and restart, detector drives changed.
`timescale 1ns/1ps
interface aliu_pin_if;
	logic [aliu_pkg::PIN_W-1:0] pins;
	logic restart;
	logic changed;
	modport main (output pins, output restart, input changed);
	modport det (input pins, input restart, output changed);
endinterface

// ---- hdl/aliu_pkg.sv ----
// aliu_pkg: constants shared by the audio link interrupt unit.
// assumes: 8-bit register port, addresses and data as printed.
package aliu_pkg;
	// register port and watched pin widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PIN_W = 4;
	// register offsets
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h02;
	localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h53;
	// bit positions shared by the flag and configuration registers; polarity is in config only
	localparam int BIT_POL = 7;
	localparam int BIT_BROKEN = 6;
	localparam int BIT_POOR = 5;
	localparam int BIT_REMOTE = 4;
	localparam int BIT_PIN = 3;
	localparam int BIT_LOST_PACKET_COUNT = 2;
	localparam int BIT_WAKE = 1;
	// masks and special values
	localparam logic [DATA_W-1:0] FLAG_MASK = 8'h7E;
	localparam logic [DATA_W-1:0] CFG_MASK = 8'hFE;
	localparam logic [DATA_W-1:0] TX_ONLY_MASK = 8'h70;
	localparam logic [DATA_W-1:0] CLEAR_ALL = 8'h7F;
	localparam logic [DATA_W-1:0] QUALITY_FULL = 8'hFF;
	// reset values
	localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
	localparam logic [DATA_W-1:0] CONFIG_RST = 8'h00;
	localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
	localparam logic [PIN_W-1:0] PINS_RST = 4'h0;
	localparam logic IRQ_RST = 1'b1;
endpackage

// ---- hdl/aliu_top.sv ----
// aliu_top: interrupt flags, configuration and request pin of the
// audio link device, for both transmitter and receiver roles.
// assumes: all inputs synchronous to clk_i; register port single
// cycle, read data valid the cycle after the read strobe.
`timescale 1ns/1ps

module aliu_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [aliu_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [aliu_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [aliu_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic role_tx_i,
	input wire logic slave_if_i,
	input wire logic powered_up_i,
	input wire logic link_broken_i,
	input wire logic remote_done_i,
	input wire logic wakeup_i,
	input wire logic [aliu_pkg::DATA_W-1:0] lost_in_14_frames_i,
	input wire logic [aliu_pkg::DATA_W-1:0] quality_warning_threshold_i,
	input wire logic [aliu_pkg::DATA_W-1:0] lost_packet_count_i,
	input wire logic [aliu_pkg::DATA_W-1:0] error_threshold_i,
	input wire logic [aliu_pkg::PIN_W-1:0] remote_input_pins_value_i,
	input wire logic [aliu_pkg::PIN_W-1:0] receiver_pin_io_value_i,
	output logic irq_o,
	output logic irq_oe_o
);
	import aliu_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] flags;
		logic [DATA_W-1:0] cfg;
		logic [DATA_W-1:0] rdata;
		logic irq;
		logic oe;
		logic role_q;
	} aliu_state_s;

	aliu_state_s st;
	aliu_state_s next_st;
	aliu_pin_if pin ();
	logic [DATA_W-1:0] link_quality_level;
	logic [DATA_W-1:0] ev;
	logic [DATA_W-1:0] clr;
	logic wr_flags;
	logic wr_cfg;
	logic active;

	// pin-change detector on the role's watched pins
	aliu_pin_change u_pin_change (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin(pin)
	);

	// watched pins follow the role; a role swap re-arms the detector
	assign pin.pins = role_tx_i ? remote_input_pins_value_i
		: receiver_pin_io_value_i;
	assign pin.restart = role_tx_i ^ st.role_q;

	// quality level from losses in the 14-frame window
	assign link_quality_level = QUALITY_FULL - lost_in_14_frames_i;

	// raw events this cycle, transmitter-only ones dropped in receiver
	always_comb begin
		ev = '0;
		ev[BIT_BROKEN] = link_broken_i;
		ev[BIT_POOR] = link_quality_level
			<= quality_warning_threshold_i;
		ev[BIT_REMOTE] = remote_done_i;
		ev[BIT_PIN] = pin.changed;
		ev[BIT_LOST_PACKET_COUNT] = lost_packet_count_i
			>= error_threshold_i;
		ev[BIT_WAKE] = wakeup_i;
		if (!role_tx_i) begin
			ev = ev & ~TX_ONLY_MASK;
		end
	end

	// register write decode
	assign wr_flags = reg_wr_i && (reg_addr_i == OFF_FLAGS);
	assign wr_cfg = reg_wr_i && (reg_addr_i == OFF_CONFIG);

	// write-one-to-clear mask; 0x7F therefore clears all flags
	assign clr = wr_flags ? (reg_wdata_i & FLAG_MASK) : '0;

	// next state: flags, configuration, read data and pin level
	always_comb begin
		next_st = st;
		next_st.role_q = role_tx_i;
		// set beats clear; flags are sticky and reads never clear
		next_st.flags = ((st.flags & ~clr) | ev)
			& FLAG_MASK;
		if (wr_cfg) begin
			next_st.cfg = reg_wdata_i & CFG_MASK;
		end
		// read data, one cycle after the strobe
		if (reg_rd_i && (reg_addr_i == OFF_FLAGS)) begin
			next_st.rdata = st.flags;
		end else if (reg_rd_i && (reg_addr_i == OFF_CONFIG)) begin
			next_st.rdata = st.cfg;
		end else if (reg_rd_i) begin
			next_st.rdata = '0;
		end
		next_st.oe = role_tx_i | slave_if_i;
		// wake-state when wakeup is enabled, else enabled flags
		if (next_st.cfg[BIT_WAKE]) begin
			active = powered_up_i;
		end else begin
			active = |(next_st.flags & next_st.cfg
				& FLAG_MASK);
		end
		next_st.irq = ~(active ^ next_st.cfg[BIT_POL]);
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st.flags <= FLAGS_RST;
			st.cfg <= CONFIG_RST;
			st.rdata <= RDATA_RST;
			st.irq <= IRQ_RST;
			st.oe <= 1'b0;
			st.role_q <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata_o = st.rdata;
	assign irq_o = st.irq;
	assign irq_oe_o = st.oe;

	// assertion helpers
	logic pending;
	assign pending = |(st.flags & st.cfg & FLAG_MASK);

	// flag register written with the clear-all value, no event present
	sequence s_clear_all;
		wr_flags && (reg_wdata_i == CLEAR_ALL) && (ev == '0);
	endsequence

	// enabled event while wakeup mode is off and config is untouched
	sequence s_enabled_event;
		(|(ev & st.cfg & FLAG_MASK)) && !st.cfg[BIT_WAKE] && !wr_cfg;
	endsequence

	// request pending with no write that could clear it or move config
	sequence s_held_request;
		pending && !st.cfg[BIT_WAKE] && !reg_wr_i;
	endsequence

	property p_polarity;
		@(posedge clk_i) disable iff (rst_i)
		(pending && !st.cfg[BIT_WAKE]) |-> (irq_o == st.cfg[BIT_POL]);
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("request pin level does not match polarity");

	property p_hold_active;
		@(posedge clk_i) disable iff (rst_i)
		s_held_request [*2] |=> (irq_o == $past(irq_o, 2));
	endproperty
	a_hold_active: assert property (p_hold_active)
		else $error("request dropped without a clearing write");

	property p_clear_all;
		@(posedge clk_i) disable iff (rst_i)
		s_clear_all |=> (st.flags == FLAGS_RST);
	endproperty
	a_clear_all: assert property (p_clear_all)
		else $error("clear-all write left a flag set");

	property p_read_keeps;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && !reg_wr_i) |=> ((st.flags & $past(st.flags))
			== $past(st.flags));
	endproperty
	a_read_keeps: assert property (p_read_keeps)
		else $error("read cleared a flag");

	property p_broken;
		@(posedge clk_i) disable iff (rst_i)
		(link_broken_i && role_tx_i) |=> st.flags[BIT_BROKEN];
	endproperty
	a_broken: assert property (p_broken)
		else $error("link break did not set its flag");

	property p_poor;
		@(posedge clk_i) disable iff (rst_i)
		(role_tx_i && (link_quality_level
			<= quality_warning_threshold_i)) |=> st.flags[BIT_POOR];
	endproperty
	a_poor: assert property (p_poor)
		else $error("poor quality did not set its flag");

	property p_lost_packet_count;
		@(posedge clk_i) disable iff (rst_i)
		(lost_packet_count_i >= error_threshold_i)
			|=> st.flags[BIT_LOST_PACKET_COUNT];
	endproperty
	a_lost_packet_count: assert property (p_lost_packet_count)
		else $error("link error did not set its flag");

	property p_disabled_idle;
		@(posedge clk_i) disable iff (rst_i)
		((st.cfg & FLAG_MASK) == '0) |-> (irq_o != st.cfg[BIT_POL]);
	endproperty
	a_disabled_idle: assert property (p_disabled_idle)
		else $error("request active with every source disabled");

	property p_wake_mode;
		@(posedge clk_i) disable iff (rst_i)
		st.cfg[BIT_WAKE] |-> (irq_o
			== ($past(powered_up_i) ~^ st.cfg[BIT_POL]));
	endproperty
	a_wake_mode: assert property (p_wake_mode)
		else $error("wakeup mode pin does not follow power state");

	property p_rx_quiet;
		@(posedge clk_i) disable iff (rst_i)
		(!role_tx_i && ((st.flags & TX_ONLY_MASK) == '0))
			|=> ((st.flags & TX_ONLY_MASK) == '0);
	endproperty
	a_rx_quiet: assert property (p_rx_quiet)
		else $error("receiver raised a transmitter-only flag");

	property p_enable_pin;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> (irq_oe_o == $past(role_tx_i | slave_if_i));
	endproperty
	a_enable_pin: assert property (p_enable_pin)
		else $error("request pin enable wrong for role");

	property p_event_to_pin;
		@(posedge clk_i) disable iff (rst_i)
		s_enabled_event |=> (irq_o == st.cfg[BIT_POL]);
	endproperty
	a_event_to_pin: assert property (p_event_to_pin)
		else $error("enabled event did not raise request next cycle");

	property p_sticky;
		@(posedge clk_i) disable iff (rst_i)
		(st.flags[BIT_LOST_PACKET_COUNT] && !wr_flags) |=> st.flags[BIT_LOST_PACKET_COUNT];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("flag dropped without a clear");

	// per-source flag setting, clearing, storage, pin enable and idle pin level checks
	property p_remote_done;
		@(posedge clk_i) disable iff (rst_i)
		(remote_done_i && role_tx_i) |=> st.flags[BIT_REMOTE];
	endproperty
	a_remote_done: assert property (p_remote_done)
		else $error("remote completion did not set its flag");

	property p_wakeup_flag;
		@(posedge clk_i) disable iff (rst_i)
		wakeup_i |=> st.flags[BIT_WAKE];
	endproperty
	a_wakeup_flag: assert property (p_wakeup_flag)
		else $error("wakeup did not set its flag");

	property p_quality_level;
		@(posedge clk_i) disable iff (rst_i)
		(role_tx_i && (lost_in_14_frames_i
			== QUALITY_FULL - quality_warning_threshold_i))
			|=> st.flags[BIT_POOR];
	endproperty
	a_quality_level: assert property (p_quality_level)
		else $error("quality equal to threshold did not set its flag");

	property p_no_slave;
		@(posedge clk_i) disable iff (rst_i)
		(!role_tx_i && !slave_if_i) |=> !irq_oe_o;
	endproperty
	a_no_slave: assert property (p_no_slave)
		else $error("request pin driven in receiver without slave port");

	property p_clear_one;
		@(posedge clk_i) disable iff (rst_i)
		(wr_flags && reg_wdata_i[BIT_LOST_PACKET_COUNT]
			&& (lost_packet_count_i < error_threshold_i))
			|=> !st.flags[BIT_LOST_PACKET_COUNT];
	endproperty
	a_clear_one: assert property (p_clear_one)
		else $error("write of one did not clear its flag");

	property p_idle_level;
		@(posedge clk_i) disable iff (rst_i)
		(!pending && !st.cfg[BIT_WAKE]) |-> (irq_o != st.cfg[BIT_POL]);
	endproperty
	a_idle_level: assert property (p_idle_level)
		else $error("request active with no enabled flag set");

	property p_rx_no_remote;
		@(posedge clk_i) disable iff (rst_i)
		(!role_tx_i && remote_done_i && !st.flags[BIT_REMOTE])
			|=> !st.flags[BIT_REMOTE];
	endproperty
	a_rx_no_remote: assert property (p_rx_no_remote)
		else $error("receiver raised the remote done flag");

	property p_cfg_write;
		@(posedge clk_i) disable iff (rst_i)
		wr_cfg |=> (st.cfg == ($past(reg_wdata_i) & CFG_MASK));
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("configuration write not stored");

	// watched pins keep their source, no role swap in between
	sequence s_role_steady;
		role_tx_i == st.role_q;
	endsequence

	property p_pin_change;
		@(posedge clk_i) disable iff (rst_i)
		s_role_steady [*2] ##0 (pin.pins != $past(pin.pins))
			|=> st.flags[BIT_PIN];
	endproperty
	a_pin_change: assert property (p_pin_change)
		else $error("watched pin change did not set its flag");
endmodule // aliu_top

// ---- test/aliu_mcu_model.sv ----
// aliu_mcu_model: external controller watching the request pin.
// assumes: the bench hands over the polarity that it wrote to config.
`timescale 1ns/1ps
module aliu_mcu_model (
	input wire logic irq_i,
	input wire logic irq_oe_i,
	input wire logic pol_i,
	output logic pending_o
);
	// a request counts only while the pin is driven at its active level
	assign pending_o = irq_oe_i & (irq_i == pol_i);
endmodule // aliu_mcu_model

// ---- test/audio_link_interrupt_unit_bench.sv ----
// audio_link_interrupt_unit_bench: self-checking bench for aliu_top.
// assumes: aliu_pkg and aliu_mcu_model compiled before this file.
`timescale 1ns/1ps
module audio_link_interrupt_unit_bench;
	import aliu_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wr = 1'b0, rd = 1'b0, role_tx = 1'b1, slave_if = 1'b0;
	logic pwr = 1'b1, broken = 1'b0, rdone = 1'b0, wake = 1'b0;
	logic pol = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, lost14 = 8'h00;
	logic [7:0] qthr = 8'h00, lost32 = 8'h00, ethr = 8'hFF;
	logic [3:0] rpins = 4'h0, xpins = 4'h0;
	logic [7:0] rdata, got;
	logic irq, irq_oe, pending;
	logic [15:0] rnd = 16'hAE3C;
	int fails = 0, checks_done = 0, cyc = 0;

	aliu_top dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .role_tx_i(role_tx), .slave_if_i(slave_if),
		.powered_up_i(pwr), .link_broken_i(broken),
		.remote_done_i(rdone), .wakeup_i(wake),
		.lost_in_14_frames_i(lost14), .quality_warning_threshold_i(qthr),
		.lost_packet_count_i(lost32), .error_threshold_i(ethr),
		.remote_input_pins_value_i(rpins),
		.receiver_pin_io_value_i(xpins), .irq_o(irq), .irq_oe_o(irq_oe));
	aliu_mcu_model mcu (.irq_i(irq), .irq_oe_i(irq_oe), .pol_i(pol),
		.pending_o(pending));

	// 25 MHz clock
	initial begin
		forever #20 clk_i = ~clk_i;
	end

	// hang guard
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			end_sim();
		end
	end

	function automatic logic [15:0] lfsr(logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	task automatic end_sim();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic tick(int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		tick(1);
	endtask

	// read data is taken on the falling edge half a cycle after the read edge
	task automatic rd_reg(logic [7:0] a);
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		got = rdata;
	endtask

	task automatic chk_reg(logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: reg got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_oe(logic exp);
		checks_done++;
		if (irq_oe !== exp) begin
			fails++;
			$display("Error %0t: pin enable %b exp %b", $time, irq_oe, exp);
		end
	endtask

	task automatic chk_pin(logic act);
		checks_done++;
		if (irq !== (act ? pol : ~pol) || pending !== act) begin
			fails++;
			$display("Error %0t: pin %b exp active %b", $time, irq, act);
		end
	endtask

	// one-cycle event for the source behind flag bit b
	task automatic fire(int b);
		case (b)
			6: broken = 1'b1;
			5: lost14 = 8'hFF - qthr;
			4: rdone = 1'b1;
			3: begin
				rpins = ~rpins;
				xpins = ~xpins;
			end
			2: lost32 = ethr;
			default: wake = 1'b1;
		endcase
		tick(1);
		broken = 1'b0;
		rdone = 1'b0;
		wake = 1'b0;
		lost14 = 8'h00;
		lost32 = 8'h00;
		tick(2);
	endtask

	// main sequence
	initial begin
		tick(12);
		rst_i = 1'b0;
		tick(1);
		rd_reg(OFF_FLAGS);
		chk_reg(FLAGS_RST);
		rd_reg(OFF_CONFIG);
		chk_reg(CONFIG_RST);
		chk_pin(1'b0);
		chk_oe(1'b1);
		wr_reg(OFF_FLAGS, CLEAR_ALL);
		rd_reg(8'h13);
		chk_reg(8'h00);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			wr_reg(OFF_CONFIG, rnd[7:0] & CFG_MASK);
			rd_reg(OFF_CONFIG);
			chk_reg(rnd[7:0] & CFG_MASK);
		end
		for (int b = 6; b >= 2; b--) begin
			rnd = lfsr(rnd);
			pol = rnd[0];
			qthr = {1'b0, rnd[7:1]};
			ethr = {1'b1, rnd[14:8]};
			wr_reg(OFF_CONFIG, {pol, 7'h00});
			fire(b);
			rd_reg(OFF_FLAGS);
			chk_reg(8'h01 << b);
			chk_pin(1'b0);
			wr_reg(OFF_CONFIG, {pol, 7'h00} | (8'h01 << b));
			chk_pin(1'b1);
			rd_reg(OFF_FLAGS);
			chk_reg(8'h01 << b);
			wr_reg(OFF_FLAGS, ~(8'h01 << b) & FLAG_MASK);
			chk_pin(1'b1);
			wr_reg(OFF_FLAGS, 8'h01 << b);
			chk_pin(1'b0);
		end
		pol = 1'b1;
		wr_reg(OFF_CONFIG, 8'h80);
		fire(1);
		rd_reg(OFF_FLAGS);
		chk_reg(8'h02);
		wr_reg(OFF_CONFIG, 8'hC2);
		chk_pin(1'b1);
		fire(6);
		pwr = 1'b0;
		tick(2);
		chk_pin(1'b0);
		pwr = 1'b1;
		tick(2);
		chk_pin(1'b1);
		wr_reg(OFF_FLAGS, CLEAR_ALL);
		rd_reg(OFF_FLAGS);
		chk_reg(8'h00);
		role_tx = 1'b0;
		wr_reg(OFF_CONFIG, 8'hF8);
		chk_oe(1'b0);
		slave_if = 1'b1;
		tick(2);
		chk_oe(1'b1);
		for (int b = 6; b >= 4; b--) begin
			fire(b);
		end
		rd_reg(OFF_FLAGS);
		chk_reg(8'h00);
		chk_pin(1'b0);
		fire(3);
		rd_reg(OFF_FLAGS);
		chk_reg(8'h08);
		chk_pin(1'b1);
		end_sim();
	end
endmodule // audio_link_interrupt_unit_bench
